/* File: logic/rsb_map.svh */
// register offsets, field positions, reset values and sizes of the slip buffer status block
`ifndef RSB_MAP_SVH
`define RSB_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets (low twelve address bits)
// ----------------------------------------------------------------
`define RSB_STATUS_OFS    12'hB08
`define RSB_MASK_OFS      12'hB0C
`define RSB_LEVEL_OFS     12'hB10

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define RSB_LOOP_LOCK_BIT 4
`define RSB_MF_LOCK_BIT   3
`define RSB_FULL_BIT      2
`define RSB_EMPTY_BIT     1
`define RSB_SLIP_BIT      0

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define RSB_EVT_RST       3'h0
`define RSB_MASK_RST      3'h0
`define RSB_FRAME_BYTES   24

`endif

/* File: logic/rsb_pkg.sv */
// types shared by the slip buffer status block
package rsb_pkg;

   // sticky event flags, msb first in register order
   typedef struct packed {
      logic full;
      logic empty;
      logic slip;
   } rsb_evt_t;

   // controlled slip taken in a cycle
   typedef enum logic [1:0] {
      RSB_NONE   = 2'b00,
      RSB_DROP   = 2'b01,
      RSB_REPEAT = 2'b10
   } rsb_slip_t;

endpackage

/* File: logic/rsb_mem.sv */
// simple dual-port memory with registered read data for the receive slip buffer
`timescale 1ns/10ps
module rsb_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 48,
   parameter int AW    = 6
) (
   input  wire logic             clk_i,   // system clock
   input  wire logic             ce_i,    // clock enable
   input  wire logic             we_i,    // write strobe
   input  wire logic [AW-1:0]    waddr_i, // write address
   input  wire logic [WIDTH-1:0] wdata_i, // write data
   input  wire logic             re_i,    // read strobe
   input  wire logic [AW-1:0]    raddr_i, // read address
   output logic      [WIDTH-1:0] rdata_o  // registered read data
);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] rdata_reg;

   always_ff @(posedge clk_i) begin
      if (ce_i && we_i) begin
         mem_reg[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i && re_i) begin
         rdata_reg <= mem_reg[raddr_i];
      end
   end

   assign rdata_o = rdata_reg;

endmodule // rsb_mem

/* File: logic/rsb_status_top.sv */
// receive slip buffer with sticky slip status, lock flags and wishbone register access
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`include "rsb_map.svh"
module rsb_status_top
   import rsb_pkg::*;
#(
   parameter int FRAME_BYTES = `RSB_FRAME_BYTES,
   parameter int DATA_W      = 8
) (
   input  wire logic              clk_i,       // 100 MHz clock
   input  wire logic              rst_i,       // sync reset, active high
   input  wire logic              ce_i,        // clock enable, freezes state when low
   // wishbone slave
   input  wire logic              wb_cyc_i,    // bus cycle
   input  wire logic              wb_stb_i,    // strobe
   input  wire logic              wb_we_i,     // write enable
   input  wire logic [11:0]       wb_adr_i,    // byte address
   input  wire logic [3:0]        wb_sel_i,    // byte lanes
   input  wire logic [31:0]       wb_dat_i,    // write data
   output logic      [31:0]       wb_dat_o,    // read data
   output logic                   wb_ack_o,    // acknowledge
   // framer side
   input  wire logic              loop_carrier_frame_lock_i, // loop-carrier framing lock
   input  wire logic              mf_lock_i,   // multiframe lock
   input  wire logic              wr_i,        // write one byte into slip buffer
   input  wire logic [DATA_W-1:0] wr_data_i,   // byte to write
   input  wire logic              rd_i,        // read one byte from slip buffer
   output logic      [DATA_W-1:0] rd_data_o,   // byte read, valid with rd_valid_o
   output logic                   rd_valid_o,  // read data valid pulse
   output logic                   irq_o        // level interrupt
);

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int DEPTH = 2 * FRAME_BYTES;
   localparam int AW    = $clog2(DEPTH);
   localparam int CW    = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C   = CW'(DEPTH);
   localparam logic [CW-1:0] FRAME_C   = CW'(FRAME_BYTES);
   localparam logic [CW-1:0] AFTER_DROP = CW'(DEPTH - FRAME_BYTES + 1);
   localparam logic [AW-1:0] FRAME_A   = AW'(FRAME_BYTES);
   localparam logic [AW-1:0] BACK_A    = AW'(DEPTH - FRAME_BYTES);
   localparam logic [AW-1:0] BACK1_A   = AW'(DEPTH - FRAME_BYTES + 1);
   localparam logic [AW-1:0] ONE_A     = AW'(1);

   function automatic logic [AW-1:0] wrap_add(input logic [AW-1:0] p,
                                              input logic [AW-1:0] inc);
      logic [AW:0] s;
      s = {1'b0, p} + {1'b0, inc};
      if (s >= (AW+1)'(DEPTH)) begin
         s = s - (AW+1)'(DEPTH);
      end
      return s[AW-1:0];
   endfunction

   // ----------------------------------------------------------------
   // slip buffer pointers
   // ----------------------------------------------------------------
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] wr_ptr_next;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW-1:0] rd_ptr_next;
   logic [CW-1:0] level_reg;
   logic [CW-1:0] level_next;
   logic          rd_valid_reg;

   wire       buf_full   = (level_reg == DEPTH_C);
   wire       buf_empty  = (level_reg == '0);
   wire       full_slip  = wr_i && buf_full && !rd_i;
   wire       empty_slip = rd_i && buf_empty;
   rsb_slip_t slip_kind;
   assign slip_kind = full_slip ? RSB_DROP : (empty_slip ? RSB_REPEAT : RSB_NONE);

   wire [CW-1:0] wr_inc = {{(CW-1){1'b0}}, wr_i};
   wire [CW-1:0] rd_dec = {{(CW-1){1'b0}}, rd_i};
   wire [AW-1:0] rd_addr = empty_slip ? wrap_add(rd_ptr_reg, BACK_A) : rd_ptr_reg;

   assign wr_ptr_next = wr_i ? wrap_add(wr_ptr_reg, ONE_A) : wr_ptr_reg;

   always_comb begin
      unique case (slip_kind)
         RSB_NONE: begin
            rd_ptr_next = rd_i ? wrap_add(rd_ptr_reg, ONE_A) : rd_ptr_reg;
            level_next  = CW'(level_reg + wr_inc - rd_dec);
         end
         RSB_DROP: begin
            // oldest frame dropped to make room
            rd_ptr_next = wrap_add(rd_ptr_reg, FRAME_A);
            level_next  = AFTER_DROP;
         end
         RSB_REPEAT: begin
            // step back one frame and read it again
            rd_ptr_next = wrap_add(rd_ptr_reg, BACK1_A);
            level_next  = CW'(FRAME_C - CW'(1) + wr_inc);
         end
         default: begin
            rd_ptr_next = rd_ptr_reg;
            level_next  = level_reg;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg   <= '0;
         rd_ptr_reg   <= '0;
         level_reg    <= '0;
         rd_valid_reg <= 1'b0;
      end else if (ce_i) begin
         wr_ptr_reg   <= wr_ptr_next;
         rd_ptr_reg   <= rd_ptr_next;
         level_reg    <= level_next;
         rd_valid_reg <= rd_i;
      end
   end

   rsb_mem #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk_i   (clk_i),
      .ce_i    (ce_i),
      .we_i    (wr_i),
      .waddr_i (wr_ptr_reg),
      .wdata_i (wr_data_i),
      .re_i    (rd_i),
      .raddr_i (rd_addr),
      .rdata_o (rd_data_o)
   );

   assign rd_valid_o = rd_valid_reg;

   // ----------------------------------------------------------------
   // wishbone decode
   // ----------------------------------------------------------------
   logic        ack_reg;
   logic [31:0] dat_reg;
   logic [2:0]  mask_reg;
   rsb_evt_t    evt_reg;
   rsb_evt_t    evt_next;
   rsb_evt_t    evt_hit;

   wire take        = wb_cyc_i && wb_stb_i && !ack_reg;
   wire sel_status  = (wb_adr_i[11:2] == 10'(`RSB_STATUS_OFS >> 2));
   wire sel_mask    = (wb_adr_i[11:2] == 10'(`RSB_MASK_OFS >> 2));
   wire sel_level   = (wb_adr_i[11:2] == 10'(`RSB_LEVEL_OFS >> 2));
   wire status_read = take && !wb_we_i && sel_status;
   wire mask_write  = take && wb_we_i && sel_mask && wb_sel_i[0];

   wire [31:0] status_word = {24'h000000, 3'h0,
                              loop_carrier_frame_lock_i,
                              mf_lock_i,
                              evt_reg};
   wire [31:0] mask_word   = {29'h00000000, mask_reg};
   wire [31:0] level_word  = {{(32-CW){1'b0}}, level_reg};
   wire [31:0] rd_mux      = sel_status ? status_word :
                             sel_mask   ? mask_word   :
                             sel_level  ? level_word  : 32'h00000000;

   // ----------------------------------------------------------------
   // sticky events, read clears, set wins
   // ----------------------------------------------------------------
   assign evt_hit.full  = full_slip;
   assign evt_hit.empty = empty_slip;
   assign evt_hit.slip  = full_slip || empty_slip;
   assign evt_next = (status_read ? rsb_evt_t'(`RSB_EVT_RST) : evt_reg) | evt_hit;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_reg  <= rsb_evt_t'(`RSB_EVT_RST);
         mask_reg <= `RSB_MASK_RST;
         ack_reg  <= 1'b0;
         dat_reg  <= 32'h00000000;
      end else if (ce_i) begin
         evt_reg  <= evt_next;
         ack_reg  <= take;
         if (take) begin
            dat_reg <= wb_we_i ? 32'h00000000 : rd_mux;
         end
         if (mask_write) begin
            mask_reg <= wb_dat_i[2:0];
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign irq_o    = |(evt_reg & mask_reg);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_status_take;
      ce_i && status_read;
   endsequence

   sequence s_answer;
      wb_ack_o && !wb_we_i;
   endsequence

   property p_loop_lock;
      s_status_take |=> s_answer
         ##0 (wb_dat_o[`RSB_LOOP_LOCK_BIT] == $past(loop_carrier_frame_lock_i));
   endproperty
   a_loop_lock: assert property (p_loop_lock)
      else $error("loop lock bit does not follow its input");

   property p_mf_lock;
      s_status_take |=> wb_dat_o[`RSB_MF_LOCK_BIT] == $past(mf_lock_i);
   endproperty
   a_mf_lock: assert property (p_mf_lock)
      else $error("multiframe lock bit does not follow its input");

   property p_full_set;
      (ce_i && wr_i && buf_full && !rd_i) |=> evt_reg.full && evt_reg.slip;
   endproperty
   a_full_set: assert property (p_full_set)
      else $error("full flag not set on write to full buffer");

   property p_empty_set;
      (ce_i && rd_i && buf_empty) |=> evt_reg.empty && evt_reg.slip;
   endproperty
   a_empty_set: assert property (p_empty_set)
      else $error("empty flag not set on read of empty buffer");

   property p_slip_only;
      (ce_i && !full_slip && !empty_slip && !evt_reg.slip) |=> !evt_reg.slip;
   endproperty
   a_slip_only: assert property (p_slip_only)
      else $error("slip flag set without a slip");

   property p_read_clear;
      (s_status_take and (!full_slip && !empty_slip)) |=> evt_reg == '0
         ##0 wb_dat_o[2:0] == $past(evt_reg);
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("status read did not report and clear events");

   property p_repeat;
      (ce_i && rd_i && buf_empty && !wr_i) |=> level_reg == FRAME_C - CW'(1)
         ##0 rd_ptr_reg == wrap_add($past(rd_ptr_reg), BACK1_A);
   endproperty
   a_repeat: assert property (p_repeat)
      else $error("empty read did not repeat a frame");

   property p_drop;
      (ce_i && full_slip) |=> level_reg == AFTER_DROP
         ##0 rd_ptr_reg == wrap_add($past(rd_ptr_reg), FRAME_A);
   endproperty
   a_drop: assert property (p_drop)
      else $error("full write did not drop a frame");

   property p_reset_clear;
      disable iff (1'b0) rst_i |=> evt_reg == '0 && level_reg == '0;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("status not cleared by reset");

   property p_ack_pulse;
      (ce_i && take) |=> wb_ack_o ##1 (!ce_i || !wb_ack_o);
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("acknowledge not a single cycle");

   property p_irq;
      (s_status_take and (!full_slip && !empty_slip)) |=> !irq_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt still high after a status read with no event");

   property p_sticky;
      (ce_i && !status_read && evt_reg.full) |=> evt_reg.full;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("full flag cleared without a status read");

   property p_level_cap;
      level_reg <= DEPTH_C;
   endproperty
   a_level_cap: assert property (p_level_cap)
      else $error("buffer level above two frames");

   property p_mask_hold;
      (ce_i && !mask_write) |=> mask_reg == $past(mask_reg);
   endproperty
   a_mask_hold: assert property (p_mask_hold)
      else $error("mask changed without a mask write");

endmodule // rsb_status_top

/* File: verification/rx_slip_buffer_status_bench.sv */
// self-checking bench of the receive slip buffer status block
`timescale 1ns/10ps
`include "rsb_map.svh"
module rx_slip_buffer_status_bench;

   localparam int FB = 4;

   logic        clk_i;
   logic        rst_i;
   logic        ce_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [11:0] wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        lc_lock;
   logic        mf_lock;
   logic        wr_i;
   logic [7:0]  wr_data_i;
   logic        rd_i;
   logic [7:0]  rd_data_o;
   logic        rd_valid_o;
   logic        irq_o;
   int          bad_count;
   int          checks;
   int          seed;
   logic [2:0]  evt;
   logic [2:0]  mask;
   logic [7:0]  q[$];
   logic [7:0]  hist[$];

   rsb_status_top #(.FRAME_BYTES(FB), .DATA_W(8)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .loop_carrier_frame_lock_i(lc_lock), .mf_lock_i(mf_lock),
      .wr_i(wr_i), .wr_data_i(wr_data_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .irq_o(irq_o)
   );

   // ----------------------------------------------------------------
   // clock, checking and closing
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // bus and buffer tasks with the reference model
   // ----------------------------------------------------------------
   task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                     output logic [31:0] rdat);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h1;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] adr, input logic [31:0] exp);
      logic [31:0] r;
      wb(1'b0, adr, 32'h0, r);
      chk(r, exp);
   endtask

   task automatic wr_reg(input logic [11:0] adr, input logic [31:0] dat);
      logic [31:0] r;
      wb(1'b1, adr, dat, r);
      if (adr == `RSB_MASK_OFS) mask = dat[2:0];
   endtask

   // status read returns pre-clear flags, then clears them
   task automatic rd_status();
      logic [31:0] r;
      wb(1'b0, `RSB_STATUS_OFS, 32'h0, r);
      chk(r, {27'h0, lc_lock, mf_lock, evt});
      evt = 3'h0;
   endtask

   task automatic chk_irq();
      #1;
      chk({31'h0, irq_o}, {31'h0, |(evt & mask)});
   endtask

   // write on a full buffer drops the oldest frame
   task automatic wr_byte();
      logic [7:0] d;
      d = 8'($random(seed));
      @(posedge clk_i);
      wr_i      <= 1'b1;
      wr_data_i <= d;
      @(posedge clk_i);
      wr_i      <= 1'b0;
      if (q.size() == 2 * FB) begin
         repeat (FB) void'(q.pop_front());
         evt = evt | 3'h5;
      end
      q.push_back(d);
   endtask

   // read on an empty buffer repeats the last frame
   task automatic rd_byte();
      logic [7:0] e;
      @(posedge clk_i);
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      if (q.size() == 0) begin
         q = hist;
         evt = evt | 3'h3;
      end
      e = q.pop_front();
      hist.push_back(e);
      if (hist.size() > FB) void'(hist.pop_front());
      chk({31'h0, rd_valid_o}, 32'h1);
      chk({24'h0, rd_data_o}, {24'h0, e});
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      #200000;
      bad_count++;
      conclude();
   end

   initial begin
      bad_count = 0;
      checks    = 0;
      seed      = 30;
      evt       = 3'h0;
      mask      = 3'h0;
      rst_i     = 1'b1;
      ce_i      = 1'b1;
      wb_cyc_i  = 1'b0;
      wb_stb_i  = 1'b0;
      wb_we_i   = 1'b0;
      wb_adr_i  = 12'h000;
      wb_sel_i  = 4'h0;
      wb_dat_i  = 32'h0;
      lc_lock   = 1'b0;
      mf_lock   = 1'b0;
      wr_i      = 1'b0;
      wr_data_i = 8'h00;
      rd_i      = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_status();
      rd_reg(`RSB_MASK_OFS, 32'h0);
      rd_reg(`RSB_LEVEL_OFS, 32'h0);
      rd_reg(12'h000, 32'h0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         lc_lock <= i[1];
         mf_lock <= i[0];
         rd_status();
      end
      lc_lock <= 1'b0;
      mf_lock <= 1'b0;
      repeat (2 * FB + 1) wr_byte();
      rd_reg(`RSB_LEVEL_OFS, 32'(FB + 1));
      chk_irq();
      wr_reg(`RSB_MASK_OFS, 32'h4);
      chk_irq();
      wr_reg(`RSB_STATUS_OFS, 32'hFF);
      rd_status();
      chk_irq();
      rd_status();
      while (q.size() > 0) rd_byte();
      rd_byte();
      rd_reg(`RSB_LEVEL_OFS, 32'(FB - 1));
      repeat (FB - 1) rd_byte();
      chk_irq();
      wr_reg(`RSB_MASK_OFS, 32'h7);
      chk_irq();
      rd_reg(`RSB_LEVEL_OFS, 32'(q.size()));
      rd_status();
      rd_status();
      conclude();
   end

endmodule // rx_slip_buffer_status_bench
